// ### hw/aer_uncorr_defines.vh
// register offsets, field masks and reset values of the uncorrectable mask/severity pair
`ifndef AER_UNCORR_DEFINES_VH
`define AER_UNCORR_DEFINES_VH
`define MASK_REG_OFFSET 12'h108
`define SEVR_REG_OFFSET 12'h10C
`define MASK_RESET_VALUE 32'h0000_0000
`define SEVR_RESET_VALUE 32'h0006_2031
`define ERR_WRITABLE_BITS 32'h001F_F010
`define SEVR_FIXED_ONES 32'h0000_0021
`define ERR_BIT_UR 20
`define ERR_BIT_ECRC 19
`define ERR_BIT_MAL 18
`define ERR_BIT_RXOVF 17
`define ERR_BIT_UNXP 16
`define ERR_BIT_CABT 15
`define ERR_BIT_CTO 14
`define ERR_BIT_FC 13
`define ERR_BIT_PSN 12
`define ERR_BIT_SD 5
`define ERR_BIT_DLL 4
`define ERR_BIT_ACS 21
`endif

// ### hw/aer_uncorrectable_mask_severity.v
// uncorrectable error mask and severity registers with event gating
`timescale 1ns/1ps
`include "aer_uncorr_defines.vh"

// Contract
// - bits 31:22 read zero in both
// - mask bit 21 reads zero
// - mask bits 20,19,18 read/write
// - mask bits 17 down to 12 read/write
// - mask bit 4 read/write
// - mask bits reset zero; one masks
// - masked error sets nothing, reports nothing
// - mask bits 11:6 read zero
// - mask bit 5 reads zero
// - mask bits 3:0 read zero
// - link, global or power-on reset clears
// - severity one fatal, zero nonfatal
// - severity register at offset 10Ch
// - severity resets to 0006 2031h
// - severity bits 20:12 and 4 writable
// - severity bit 21 reads zero
// - severity bits 11:6 read zero
// - severity bit 5 reads one
// - severity bits 3:1 read zero
// - severity bit 0 reads one
// - mask register at 108h, resets zero
module aer_uncorrectable_mask_severity
(
	input wire mclk_i,
	input wire reset_n_i,
	input wire link_reset_i,
	input wire global_reset_pin_n_i,
	input wire cfg_wr_i,
	input wire cfg_rd_i,
	input wire [11:0] cfg_addr_i,
	input wire [31:0] cfg_wdata_i,
	input wire [3:0] cfg_be_i,
	output reg [31:0] cfg_rdata_o,
	output reg cfg_rvalid_o,
	input wire [31:0] err_event_i,
	output reg [31:0] err_logged_o,
	output reg err_fatal_msg_o,
	output reg err_nonfatal_msg_o,
	output wire [31:0] err_hide_o,
	output wire [31:0] err_fatal_sel_o
);

	// ==========================================================
	// global reset pin synchroniser and soft clear
	reg [2:0] global_reset_pin_sync_reg;
	reg global_reset_pin_state_reg;
	wire soft_clear;

	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			global_reset_pin_sync_reg <= 3'h7;
			global_reset_pin_state_reg <= 1'b1;
		end
		else
		begin
			global_reset_pin_sync_reg <= {global_reset_pin_sync_reg[1:0], global_reset_pin_n_i};
			if (global_reset_pin_sync_reg[2] == global_reset_pin_sync_reg[1])
				global_reset_pin_state_reg <= global_reset_pin_sync_reg[1];
		end
	end

	assign soft_clear = link_reset_i | ~global_reset_pin_state_reg;

	// ==========================================================
	// byte-enable merge of writable bits
	function [31:0] merge_write;
		input [31:0] old_val;
		input [31:0] wdata;
		input [3:0] be;
		reg [31:0] lane;
		begin
			lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			merge_write = ((old_val & ~(lane & `ERR_WRITABLE_BITS)) |
				(wdata & lane & `ERR_WRITABLE_BITS)) & `ERR_WRITABLE_BITS;
		end
	endfunction

	// ==========================================================
	// register address decode
	function addr_match;
		input [11:0] addr;
		input [11:0] offset;
		begin
			addr_match = (addr[11:2] == offset[11:2]);
		end
	endfunction

	// ==========================================================
	// mask and severity storage
	reg [31:0] mask_reg;
	reg [31:0] mask_next;
	reg [31:0] sevr_reg;
	reg [31:0] sevr_next;
	wire mask_hit;
	wire sevr_hit;
	wire mask_read;
	wire sevr_read;

	assign mask_hit = addr_match(cfg_addr_i, `MASK_REG_OFFSET);
	assign sevr_hit = addr_match(cfg_addr_i, `SEVR_REG_OFFSET);
	assign mask_read = cfg_rd_i & mask_hit;
	assign sevr_read = cfg_rd_i & sevr_hit;

	always @*
	begin
		mask_next = mask_reg;
		sevr_next = sevr_reg;
		if (cfg_wr_i && mask_hit)
			mask_next = merge_write(mask_reg, cfg_wdata_i, cfg_be_i);
		if (cfg_wr_i && sevr_hit)
			sevr_next = merge_write(sevr_reg, cfg_wdata_i, cfg_be_i);
		if (soft_clear)
		begin
			mask_next = `MASK_RESET_VALUE;
			sevr_next = `SEVR_RESET_VALUE & `ERR_WRITABLE_BITS;
		end
	end

	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mask_reg <= `MASK_RESET_VALUE;
			sevr_reg <= `SEVR_RESET_VALUE & `ERR_WRITABLE_BITS;
		end
		else
		begin
			mask_reg <= mask_next;
			sevr_reg <= sevr_next;
		end
	end

	// ==========================================================
	// named mask fields
	wire unsupported_request_hide;
	wire end_to_end_crc_hide;
	wire malformed_packet_hide;
	wire receiver_overflow_hide;
	wire unexpected_completion_hide;
	wire completer_abort_hide;
	wire completion_timeout_hide;
	wire flow_control_fault_hide;
	wire poisoned_packet_hide;
	wire link_protocol_fault_hide;
	reg [31:0] hide_word;

	assign unsupported_request_hide = mask_reg[`ERR_BIT_UR];
	assign end_to_end_crc_hide = mask_reg[`ERR_BIT_ECRC];
	assign malformed_packet_hide = mask_reg[`ERR_BIT_MAL];
	assign receiver_overflow_hide = mask_reg[`ERR_BIT_RXOVF];
	assign unexpected_completion_hide = mask_reg[`ERR_BIT_UNXP];
	assign completer_abort_hide = mask_reg[`ERR_BIT_CABT];
	assign completion_timeout_hide = mask_reg[`ERR_BIT_CTO];
	assign flow_control_fault_hide = mask_reg[`ERR_BIT_FC];
	assign poisoned_packet_hide = mask_reg[`ERR_BIT_PSN];
	assign link_protocol_fault_hide = mask_reg[`ERR_BIT_DLL];

	// fixed mask bits 31:22, 21, 11:6, 5 and 3:0 stay zero
	always @*
	begin
		hide_word = 32'h0000_0000;
		hide_word[`ERR_BIT_UR] = unsupported_request_hide;
		hide_word[`ERR_BIT_ECRC] = end_to_end_crc_hide;
		hide_word[`ERR_BIT_MAL] = malformed_packet_hide;
		hide_word[`ERR_BIT_RXOVF] = receiver_overflow_hide;
		hide_word[`ERR_BIT_UNXP] = unexpected_completion_hide;
		hide_word[`ERR_BIT_CABT] = completer_abort_hide;
		hide_word[`ERR_BIT_CTO] = completion_timeout_hide;
		hide_word[`ERR_BIT_FC] = flow_control_fault_hide;
		hide_word[`ERR_BIT_PSN] = poisoned_packet_hide;
		hide_word[`ERR_BIT_DLL] = link_protocol_fault_hide;
	end

	assign err_hide_o = hide_word;

	// ==========================================================
	// named severity fields
	wire unsupported_request_fatal;
	wire end_to_end_crc_fatal;
	wire malformed_packet_fatal;
	wire receiver_overflow_fatal;
	wire unexpected_completion_fatal;
	wire completer_abort_fatal;
	wire completion_timeout_fatal;
	wire flow_control_fault_fatal;
	wire poisoned_packet_fatal;
	wire link_protocol_fault_fatal;
	reg [31:0] fatal_word;

	assign unsupported_request_fatal = sevr_reg[`ERR_BIT_UR];
	assign end_to_end_crc_fatal = sevr_reg[`ERR_BIT_ECRC];
	assign malformed_packet_fatal = sevr_reg[`ERR_BIT_MAL];
	assign receiver_overflow_fatal = sevr_reg[`ERR_BIT_RXOVF];
	assign unexpected_completion_fatal = sevr_reg[`ERR_BIT_UNXP];
	assign completer_abort_fatal = sevr_reg[`ERR_BIT_CABT];
	assign completion_timeout_fatal = sevr_reg[`ERR_BIT_CTO];
	assign flow_control_fault_fatal = sevr_reg[`ERR_BIT_FC];
	assign poisoned_packet_fatal = sevr_reg[`ERR_BIT_PSN];
	assign link_protocol_fault_fatal = sevr_reg[`ERR_BIT_DLL];

	// fixed severity bits: 5 and 0 one, the rest zero
	always @*
	begin
		fatal_word = `SEVR_FIXED_ONES;
		fatal_word[`ERR_BIT_UR] = unsupported_request_fatal;
		fatal_word[`ERR_BIT_ECRC] = end_to_end_crc_fatal;
		fatal_word[`ERR_BIT_MAL] = malformed_packet_fatal;
		fatal_word[`ERR_BIT_RXOVF] = receiver_overflow_fatal;
		fatal_word[`ERR_BIT_UNXP] = unexpected_completion_fatal;
		fatal_word[`ERR_BIT_CABT] = completer_abort_fatal;
		fatal_word[`ERR_BIT_CTO] = completion_timeout_fatal;
		fatal_word[`ERR_BIT_FC] = flow_control_fault_fatal;
		fatal_word[`ERR_BIT_PSN] = poisoned_packet_fatal;
		fatal_word[`ERR_BIT_DLL] = link_protocol_fault_fatal;
	end

	assign err_fatal_sel_o = fatal_word;

	// ==========================================================
	// read port
	reg [31:0] read_word;

	always @*
	begin
		read_word = 32'h0000_0000;
		case ({sevr_read, mask_read})
			2'h1: read_word = err_hide_o;
			2'h2: read_word = err_fatal_sel_o;
			default: read_word = 32'h0000_0000;
		endcase
	end

	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cfg_rdata_o <= 32'h0000_0000;
			cfg_rvalid_o <= 1'b0;
		end
		else
		begin
			cfg_rvalid_o <= cfg_rd_i;
			cfg_rdata_o <= read_word;
		end
	end

	// ==========================================================
	// event gating and message class
	reg [31:0] live_err;
	reg [31:0] fatal_hits;
	wire [31:0] nonfatal_hits;

	// only supported, unmasked events go on
	always @*
	begin
		live_err = 32'h0000_0000;
		live_err[`ERR_BIT_UR] = err_event_i[`ERR_BIT_UR] & ~unsupported_request_hide;
		live_err[`ERR_BIT_ECRC] = err_event_i[`ERR_BIT_ECRC] & ~end_to_end_crc_hide;
		live_err[`ERR_BIT_MAL] = err_event_i[`ERR_BIT_MAL] & ~malformed_packet_hide;
		live_err[`ERR_BIT_RXOVF] = err_event_i[`ERR_BIT_RXOVF] & ~receiver_overflow_hide;
		live_err[`ERR_BIT_UNXP] = err_event_i[`ERR_BIT_UNXP] & ~unexpected_completion_hide;
		live_err[`ERR_BIT_CABT] = err_event_i[`ERR_BIT_CABT] & ~completer_abort_hide;
		live_err[`ERR_BIT_CTO] = err_event_i[`ERR_BIT_CTO] & ~completion_timeout_hide;
		live_err[`ERR_BIT_FC] = err_event_i[`ERR_BIT_FC] & ~flow_control_fault_hide;
		live_err[`ERR_BIT_PSN] = err_event_i[`ERR_BIT_PSN] & ~poisoned_packet_hide;
		live_err[`ERR_BIT_DLL] = err_event_i[`ERR_BIT_DLL] & ~link_protocol_fault_hide;
	end

	always @*
	begin
		fatal_hits = 32'h0000_0000;
		fatal_hits[`ERR_BIT_UR] = live_err[`ERR_BIT_UR] & unsupported_request_fatal;
		fatal_hits[`ERR_BIT_ECRC] = live_err[`ERR_BIT_ECRC] & end_to_end_crc_fatal;
		fatal_hits[`ERR_BIT_MAL] = live_err[`ERR_BIT_MAL] & malformed_packet_fatal;
		fatal_hits[`ERR_BIT_RXOVF] = live_err[`ERR_BIT_RXOVF] & receiver_overflow_fatal;
		fatal_hits[`ERR_BIT_UNXP] = live_err[`ERR_BIT_UNXP] & unexpected_completion_fatal;
		fatal_hits[`ERR_BIT_CABT] = live_err[`ERR_BIT_CABT] & completer_abort_fatal;
		fatal_hits[`ERR_BIT_CTO] = live_err[`ERR_BIT_CTO] & completion_timeout_fatal;
		fatal_hits[`ERR_BIT_FC] = live_err[`ERR_BIT_FC] & flow_control_fault_fatal;
		fatal_hits[`ERR_BIT_PSN] = live_err[`ERR_BIT_PSN] & poisoned_packet_fatal;
		fatal_hits[`ERR_BIT_DLL] = live_err[`ERR_BIT_DLL] & link_protocol_fault_fatal;
	end

	assign nonfatal_hits = live_err & ~fatal_hits;

	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			err_logged_o <= 32'h0000_0000;
			err_fatal_msg_o <= 1'b0;
			err_nonfatal_msg_o <= 1'b0;
		end
		else
		begin
			err_logged_o <= live_err;
			err_fatal_msg_o <= |fatal_hits;
			err_nonfatal_msg_o <= |nonfatal_hits;
		end
	end

endmodule // aer_uncorrectable_mask_severity

// ### dv/host_model.sv
// upstream host issuing config accesses
`timescale 1ns/1ps
module host_model(
	input wire mclk_i,
	output logic wr_o = 0,
	output logic rd_o = 0,
	output logic [11:0] addr_o = 0,
	output logic [31:0] wdata_o = 0,
	output logic [3:0] be_o = 0
);
task wr(input [11:0] a, input [31:0] d, input [3:0] b);
	@(posedge mclk_i);
	wr_o <= 1;
	addr_o <= a;
	wdata_o <= d;
	be_o <= b;
	@(posedge mclk_i);
	wr_o <= 0;
	wdata_o <= ~d;
endtask
task rd(input [11:0] a);
	@(posedge mclk_i);
	rd_o <= 1;
	addr_o <= a;
	@(posedge mclk_i);
	rd_o <= 0;
endtask
endmodule // host_model

// ### dv/aer_uncorrectable_mask_severity_asserts.sv
// port assertions of the mask and severity registers
`timescale 1ns/1ps
module aer_uncorrectable_mask_severity_asserts(
	input wire mclk_i, input wire reset_n_i, input wire link_reset_i, input wire cfg_wr_i, input wire cfg_rd_i,
	input wire [11:0] cfg_addr_i, input wire [31:0] cfg_wdata_i, input wire [3:0] cfg_be_i,
	input wire cfg_rvalid_o, input wire [31:0] err_event_i, input wire [31:0] err_logged_o,
	input wire err_fatal_msg_o, input wire err_nonfatal_msg_o,
	input wire [31:0] err_hide_o, input wire [31:0] err_fatal_sel_o
);
localparam W = 32'h001FF010;
wire [31:0] live = err_event_i & ~err_hide_o & W;
wire wall = cfg_wr_i && cfg_be_i == 4'hF && !link_reset_i;
default clocking @(posedge mclk_i); endclocking
default disable iff (!reset_n_i);
property p_rv; cfg_rd_i |=> cfg_rvalid_o; endproperty
property p_hz; (err_hide_o & ~W) == 0; endproperty
property p_fx; (err_fatal_sel_o & ~W) == 32'h21; endproperty
property p_wm; wall && cfg_addr_i == 12'h108 |=> err_hide_o == ($past(cfg_wdata_i) & W); endproperty
property p_ws; wall && cfg_addr_i == 12'h10C |=> err_fatal_sel_o == ($past(cfg_wdata_i) & W | 32'h21); endproperty
property p_lr; link_reset_i |=> err_hide_o == 0 && err_fatal_sel_o == 32'h00062031; endproperty
property p_lg; |live |=> err_logged_o == $past(live); endproperty
property p_q; live == 0 |=> !err_fatal_msg_o && !err_nonfatal_msg_o && err_logged_o == 0; endproperty
property p_ft; |(live & err_fatal_sel_o) |=> err_fatal_msg_o; endproperty
property p_nf; |(live & ~err_fatal_sel_o) |=> err_nonfatal_msg_o; endproperty
a_rv: assert property(p_rv) else $error("read not answered");
a_hz: assert property(p_hz) else $error("fixed mask bit set");
a_fx: assert property(p_fx) else $error("fixed severity bits wrong");
a_wm: assert property(p_wm) else $error("mask write lost");
a_ws: assert property(p_ws) else $error("severity write lost");
a_lr: assert property(p_lr) else $error("link reset missed");
a_lg: assert property(p_lg) else $error("logged bits wrong");
a_q: assert property(p_q) else $error("masked error reported");
a_ft: assert property(p_ft) else $error("fatal message missing");
a_nf: assert property(p_nf) else $error("nonfatal message missing");
c_rv: cover property(cfg_rvalid_o);
c_ft: cover property(err_fatal_msg_o);
c_nf: cover property(err_nonfatal_msg_o);
endmodule // aer_uncorrectable_mask_severity_asserts

// ### dv/aer_uncorrectable_mask_severity_tb.sv
// bench for the mask and severity registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("unexpected %0t %h %h", $time, a, e); end end
module aer_uncorrectable_mask_severity_tb;
logic mclk_i = 0, reset_n_i = 0, link_reset_i = 0, gr_n = 1, wr, rd, rv, fm, nm;
logic [11:0] ad;
logic [31:0] wd, ev = 0, rdat, logd, hide, fsel;
logic [3:0] be;
int miscompares = 0, n_compared = 0, cyc = 0;
always #5 mclk_i = ~mclk_i;
host_model u_host_model(.mclk_i(mclk_i), .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd), .be_o(be));
aer_uncorrectable_mask_severity u_aer_uncorrectable_mask_severity(.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.link_reset_i(link_reset_i), .global_reset_pin_n_i(gr_n), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(ad),
	.cfg_wdata_i(wd), .cfg_be_i(be), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv), .err_event_i(ev), .err_logged_o(logd),
	.err_fatal_msg_o(fm), .err_nonfatal_msg_o(nm), .err_hide_o(hide), .err_fatal_sel_o(fsel));
task rc(input [11:0] a, input [31:0] e);
	u_host_model.rd(a);
	#1 `CHK({rv, rdat}, {1'b1, e})
endtask
task evt(input [31:0] e, input [33:0] x);
	@(posedge mclk_i) ev <= e;
	@(posedge mclk_i) ev <= 0;
	#1 `CHK({fm, nm, logd}, x)
endtask
task t_write;
	rc(12'h108, 32'h0);
	rc(12'h10C, 32'h00062031);
	rc(12'h110, 32'h0);
	u_host_model.wr(12'h108, 32'hFFFFFFFF, 4'hF);
	rc(12'h108, 32'h001FF010);
	u_host_model.wr(12'h10C, 32'h0, 4'hF);
	rc(12'h10C, 32'h00000021);
	u_host_model.wr(12'h10C, 32'hFFFFFFFF, 4'hF);
	rc(12'h10C, 32'h001FF031);
endtask
task t_event;
	evt(32'h2000, 34'h0);
	u_host_model.wr(12'h108, 32'h0, 4'hF);
	evt(32'h2000, {2'b10, 32'h2000});
	u_host_model.wr(12'h10C, 32'h0, 4'hF);
	evt(32'h10, {2'b01, 32'h10});
	evt(32'h20, 34'h0);
endtask
task t_resets;
	u_host_model.wr(12'h108, 32'hFFFFFFFF, 4'h4);
	rc(12'h108, 32'h001F0000);
	`CHK({hide, fsel}, {32'h001F0000, 32'h00000021})
	@(posedge mclk_i) link_reset_i <= 1;
	@(posedge mclk_i) link_reset_i <= 0;
	rc(12'h10C, 32'h00062031);
	rc(12'h108, 32'h0);
	evt(32'h2000, {2'b10, 32'h2000});
	evt(32'h100000, {2'b01, 32'h100000});
	u_host_model.wr(12'h108, 32'hFFFFFFFF, 4'h1);
	rc(12'h108, 32'h00000010);
	u_host_model.wr(12'h10C, 32'h0, 4'hF);
	@(posedge mclk_i) gr_n <= 0;
	repeat (5) @(posedge mclk_i);
	gr_n <= 1;
	rc(12'h108, 32'h0);
	rc(12'h10C, 32'h00062031);
endtask
task wrap_up;
	$display("compared %0d miscompares %0d", n_compared, miscompares);
	if (miscompares == 0 && n_compared > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
initial
begin
	repeat (12) @(posedge mclk_i);
	reset_n_i <= 1;
	t_write;
	t_event;
	t_resets;
	wrap_up;
end
always @(posedge mclk_i)
begin
	cyc++;
	if (cyc == 2000)
	begin
		miscompares++;
		wrap_up;
	end
end
endmodule // aer_uncorrectable_mask_severity_tb
bind aer_uncorrectable_mask_severity aer_uncorrectable_mask_severity_asserts u_aer_uncorrectable_mask_severity_asserts(
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link_reset_i(link_reset_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
	.cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i), .cfg_rvalid_o(cfg_rvalid_o),
	.err_event_i(err_event_i), .err_logged_o(err_logged_o), .err_fatal_msg_o(err_fatal_msg_o),
	.err_nonfatal_msg_o(err_nonfatal_msg_o), .err_hide_o(err_hide_o), .err_fatal_sel_o(err_fatal_sel_o));
